// >>> logic/motion_cmd_regs.vh
// Register offsets, field positions, reset values and command codes for the decoder
`ifndef MOTION_CMD_REGS_VH
`define MOTION_CMD_REGS_VH

// Register byte addresses
`define REG_CMD          8'h00
`define REG_ARG0         8'h04
`define REG_ARG1         8'h08
`define REG_VEL0         8'h10
`define REG_VEL1         8'h14
`define REG_VEL2         8'h18
`define REG_VEL3         8'h1C
`define REG_MAX_ACCEL_SETTING       8'h20
`define REG_DECEL        8'h24
`define REG_RINGPOS      8'h28
`define REG_STATUS       8'h2C
`define REG_ACTVEL0      8'h30
`define REG_ACTVEL1      8'h34
`define REG_ACTVEL2      8'h38
`define REG_ACTVEL3      8'h3C

// Command codes
`define CMD_ROLE_SELECT  8'h87
`define CMD_AXIS_SET     8'h6F
`define CMD_VEL_HOLD     8'h70

// Reset values
`define ROLE_RESET       8'h00
`define MASK_RESET       4'h0
`define ACCEL_RESET      32'h0000_0000

// Status field positions
`define ST_SLAVE_BIT     0
`define ST_IGNORED_BIT   1
`define ST_PEND_LSB      4
`define ST_MASK_LSB      8
`define ST_VHOLD_LSB     12

// Fixed-point velocity width, axis count and axis-set buffer depth
`define VEL_SIG_BITS     27
`define AXIS_COUNT       4
`define SET_DEPTH        3

// AXI response codes
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// >>> logic/motion_command_decoder.v
// Real-time command decoder with AXI4-Lite register access
// Function
// - Role argument resets to zero, giving the master role.
// - Axis-set change, code 6Fh, carries mask and 8-byte-entry position.
// - At programmed position contouring switches to the new axis mask.
// - Three levels of buffering hold pending axis-set changes.
// - Mask bit zero selects axis one.
// - Velocity-hold, code 70h, carries mask and one 32-bit velocity per axis.
// - Velocity is 27-bit two's complement, sign extended, 16.16 format.
// - Velocity loop uses the control-law gains.
// - Selected axes ramp to velocity limited by max acceleration.
// - Velocity-hold ignored when max acceleration setting is zero.
// - Position loop stays outer loop during velocity hold.
// - Role select, code 87h: zero is master, nonzero slave.
// - Card adopts master role after reset.
// - Velocity-hold ignored for decelerating axis; ignored flag raised.
`timescale 1ns/10ps
`include "motion_cmd_regs.vh"

module motion_command_decoder #(
    parameter AXES  = `AXIS_COUNT,
    parameter DEPTH = `SET_DEPTH
) (
    input  wire        clk_in,             // 125 MHz clock
    input  wire        resetn_in,          // Async reset, active low
    input  wire [7:0]  s_axi_awaddr_in,    // Write address
    input  wire        s_axi_awvalid_in,   // Write address valid
    output wire        s_axi_awready_out,  // Write address ready
    input  wire [31:0] s_axi_wdata_in,     // Write data
    input  wire [3:0]  s_axi_wstrb_in,     // Write strobes
    input  wire        s_axi_wvalid_in,    // Write data valid
    output wire        s_axi_wready_out,   // Write data ready
    output wire [1:0]  s_axi_bresp_out,    // Write response
    output wire        s_axi_bvalid_out,   // Write response valid
    input  wire        s_axi_bready_in,    // Write response ready
    input  wire [7:0]  s_axi_araddr_in,    // Read address
    input  wire        s_axi_arvalid_in,   // Read address valid
    output wire        s_axi_arready_out,  // Read address ready
    output wire [31:0] s_axi_rdata_out,    // Read data
    output wire [1:0]  s_axi_rresp_out,    // Read response
    output wire        s_axi_rvalid_out,   // Read data valid
    input  wire        s_axi_rready_in,    // Read data ready
    input  wire [7:0]  contour_pos_in,     // Contouring entry being consumed
    input  wire        contour_step_in,    // Pulse: contouring took a point
    input  wire [3:0]  axis_stopping_in,   // Axes still halting from a stop
    output wire        slave_role_out,     // High in slave role
    output wire [3:0]  contour_mask_out,   // Axes used for contouring
    output wire [3:0]  vel_hold_out,       // Axes in velocity hold
    output wire [4*32-1:0] vel_cmd_out,    // Ramped velocity per axis
    output wire        pos_loop_outer_out  // Position loop stays closed
);

    // Bus state
    reg        aw_q, w_q, bvalid_q, rvalid_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q, rdata_q;
    reg [3:0]  wstrb_q;
    reg [1:0]  bresp_q, rresp_q;
    // Block state
    reg [7:0]  role_q;
    reg [7:0]  arg0_q, arg1_q;
    reg [31:0] vel_tgt_q [0:AXES-1];
    reg [31:0] vel_act_q [0:AXES-1];
    reg [31:0] accel_q;
    reg [3:0]  mask_q, vhold_q;
    reg        ignored_q;
    reg [3:0]  pend_mask_q [0:DEPTH-1];
    reg [7:0]  pend_pos_q  [0:DEPTH-1];
    reg [1:0]  pend_cnt_q;
    integer    i;

    // Sign extension of a 27-bit velocity
    function [31:0] sext_vel;
        input [31:0] v;
        begin
            sext_vel = {{5{v[26]}}, v[26:0]};
        end
    endfunction

    // Merge written bytes into an old word under the strobes
    function [31:0] strb_mix;
        input [31:0] old;
        input [31:0] dat;
        input [31:0] msk;
        begin
            strb_mix = (dat & msk) | (old & ~msk);
        end
    endfunction

    // Ramp one axis toward target by at most step
    function [31:0] ramp;
        input [31:0] act;
        input [31:0] tgt;
        input [31:0] step;
        reg   [32:0] diff;
        begin
            diff = {tgt[31], tgt} - {act[31], act};
            if (diff[32] == 1'b0 && diff > {1'b0, step})
                ramp = act + step;
            else if (diff[32] == 1'b1 && (33'h0 - diff) > {1'b0, step})
                ramp = act - step;
            else
                ramp = tgt;
        end
    endfunction

    wire wr_go = aw_q && w_q && !bvalid_q;
    wire rd_go = s_axi_arvalid_in && !rvalid_q;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire        cmd_wr  = wr_go && awaddr_q == `REG_CMD && wstrb_q[0];
    wire [3:0]  arg_msk = arg0_q[3:0];
    wire [31:0] status  = {16'h0, vhold_q, mask_q, 2'b00, pend_cnt_q,
                           2'b00, ignored_q, (role_q != 8'h00)};
    wire        hit     = pend_cnt_q != 2'd0 && contour_step_in
                          && contour_pos_in == pend_pos_q[0];

    assign s_axi_awready_out = !aw_q;
    assign s_axi_wready_out  = !w_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    assign slave_role_out    = role_q != 8'h00;
    assign contour_mask_out  = mask_q;
    assign vel_hold_out      = vhold_q;
    assign vel_cmd_out = {vel_act_q[3], vel_act_q[2], vel_act_q[1], vel_act_q[0]};
    assign pos_loop_outer_out = 1'b1;

    // Write channel capture and response
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bresp_q  <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_in && !aw_q)
            begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_q)
            begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
            end
            if (wr_go)
            begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q <= `REG_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready_in)
                bvalid_q <= 1'b0;
        end
    end

    // Read channel
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= `RESP_OKAY;
            case (s_axi_araddr_in)
                `REG_ARG0:    rdata_q <= {24'h0, arg0_q};
                `REG_ARG1:    rdata_q <= {24'h0, arg1_q};
                `REG_VEL0:    rdata_q <= vel_tgt_q[0];
                `REG_VEL1:    rdata_q <= vel_tgt_q[1];
                `REG_VEL2:    rdata_q <= vel_tgt_q[2];
                `REG_VEL3:    rdata_q <= vel_tgt_q[3];
                `REG_MAX_ACCEL_SETTING:  rdata_q <= accel_q;
                `REG_RINGPOS: rdata_q <= {24'h0, pend_pos_q[0]};
                `REG_STATUS:  rdata_q <= status;
                `REG_ACTVEL0: rdata_q <= vel_act_q[0];
                `REG_ACTVEL1: rdata_q <= vel_act_q[1];
                `REG_ACTVEL2: rdata_q <= vel_act_q[2];
                `REG_ACTVEL3: rdata_q <= vel_act_q[3];
                `REG_CMD:     rdata_q <= 32'h0000_0000;
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready_in)
            rvalid_q <= 1'b0;
    end

    // Argument, setting and command execution
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            role_q     <= `ROLE_RESET;
            arg0_q     <= 8'h00;
            arg1_q     <= 8'h00;
            accel_q    <= `ACCEL_RESET;
            mask_q     <= `MASK_RESET;
            vhold_q    <= 4'h0;
            ignored_q  <= 1'b0;
            pend_cnt_q <= 2'd0;
            for (i = 0; i < AXES; i = i + 1)
            begin
                vel_tgt_q[i] <= 32'h0000_0000;
                vel_act_q[i] <= 32'h0000_0000;
            end
            for (i = 0; i < DEPTH; i = i + 1)
            begin
                pend_mask_q[i] <= 4'h0;
                pend_pos_q[i]  <= 8'h00;
            end
        end
        else
        begin
            // Plain argument and setting writes
            if (wr_go)
            begin
                case (awaddr_q)
                    `REG_ARG0:   arg0_q <= (wdata_q[7:0] & wmask[7:0]) | (arg0_q & ~wmask[7:0]);
                    `REG_ARG1:   arg1_q <= (wdata_q[7:0] & wmask[7:0]) | (arg1_q & ~wmask[7:0]);
                    `REG_VEL0:   vel_tgt_q[0] <= sext_vel(strb_mix(vel_tgt_q[0], wdata_q, wmask));
                    `REG_VEL1:   vel_tgt_q[1] <= sext_vel(strb_mix(vel_tgt_q[1], wdata_q, wmask));
                    `REG_VEL2:   vel_tgt_q[2] <= sext_vel(strb_mix(vel_tgt_q[2], wdata_q, wmask));
                    `REG_VEL3:   vel_tgt_q[3] <= sext_vel(strb_mix(vel_tgt_q[3], wdata_q, wmask));
                    `REG_MAX_ACCEL_SETTING: accel_q <= strb_mix(accel_q, wdata_q, wmask);
                    `REG_STATUS: if (wstrb_q[0] && wdata_q[`ST_IGNORED_BIT]) ignored_q <= 1'b0;
                    default:     ;
                endcase
            end
            // Pending axis-set change reaches its position
            if (hit)
            begin
                mask_q <= pend_mask_q[0];
                pend_mask_q[0] <= pend_mask_q[1];
                pend_pos_q[0]  <= pend_pos_q[1];
                pend_mask_q[1] <= pend_mask_q[2];
                pend_pos_q[1]  <= pend_pos_q[2];
            end
            // Command dispatch
            if (cmd_wr)
            begin
                case (wdata_q[7:0])
                    `CMD_ROLE_SELECT: role_q <= arg0_q;
                    `CMD_AXIS_SET:
                    begin
                        // Queue in three-level buffer; full queue flags ignored unless a hit frees an entry in the same cycle
                        if (pend_cnt_q == 2'd3 && !hit)
                            ignored_q <= 1'b1;
                        else
                        begin
                            pend_mask_q[pend_cnt_q - {1'b0, hit}] <= arg_msk;
                            pend_pos_q[pend_cnt_q - {1'b0, hit}]  <= arg1_q;
                        end
                    end
                    `CMD_VEL_HOLD:
                    begin
                        if (accel_q == 32'h0000_0000)
                            ignored_q <= 1'b1;
                        else
                        begin
                            vhold_q <= vhold_q | (arg_msk & ~axis_stopping_in);
                            if ((arg_msk & axis_stopping_in) != 4'h0)
                                ignored_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            // Queue occupancy
            if (cmd_wr && wdata_q[7:0] == `CMD_AXIS_SET && !(pend_cnt_q == 2'd3 && !hit))
                pend_cnt_q <= pend_cnt_q + {1'b0, !hit};
            else if (hit)
                pend_cnt_q <= pend_cnt_q - 2'd1;
            // Velocity ramp for held axes
            for (i = 0; i < AXES; i = i + 1)
                if (vhold_q[i])
                    vel_act_q[i] <= ramp(vel_act_q[i], vel_tgt_q[i], accel_q);
        end
    end

endmodule // motion_command_decoder

// >>> test/motion_command_checker_sva.sv
// Port assertions for the motion command decoder
`timescale 1ns/10ps
module motion_command_checker (
    input wire         clk_in, resetn_in,                     // Clock, reset
    input wire         s_axi_arvalid_in, s_axi_arready_out,   // Read address
    input wire         s_axi_rvalid_out, s_axi_bvalid_out,    // Answers
    input wire         contour_step_in, slave_role_out,       // Step, role
    input wire         pos_loop_outer_out,                    // Outer loop
    input wire [3:0]   contour_mask_out, axis_stopping_in,    // Masks
    input wire [3:0]   vel_hold_out,                          // Held axes
    input wire [127:0] vel_cmd_out                            // Velocities
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // Loop structure, role and mask timing
    chk_outer_loop: assert property (pos_loop_outer_out == 1'b1)
        else $error("position loop not outer");
    chk_mask_on_step: assert property
        ($changed(contour_mask_out) |-> $past(contour_step_in))
        else $error("contour mask changed without a step");
    chk_cmd_on_write: assert property
        (($changed(slave_role_out) || $changed(vel_hold_out)) |-> $rose(s_axi_bvalid_out))
        else $error("command effect without a write");
    chk_reset_master: assert property (!$past(resetn_in) |-> !slave_role_out)
        else $error("slave role after reset");
    // Velocity hold selection, idle axis 0 and read answer
    chk_hold_sticky: assert property
        ((vel_hold_out & $past(vel_hold_out)) == $past(vel_hold_out))
        else $error("velocity hold dropped");
    chk_stop_excluded: assert property
        (((vel_hold_out & ~$past(vel_hold_out)) & $past(axis_stopping_in)) == 4'h0)
        else $error("stopping axis entered hold");
    chk_idle_zero: assert property (!vel_hold_out[0] |-> vel_cmd_out[31:0] == 32'h0)
        else $error("idle axis has velocity");
    chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read not answered");
    // Main scenarios
    cov_slave: cover property ($rose(slave_role_out));
    cov_mask: cover property ($changed(contour_mask_out));
    cov_hold: cover property ($rose(vel_hold_out[1]));
endmodule // motion_command_checker

bind motion_command_decoder motion_command_checker chk (
    .clk_in             (clk_in),
    .resetn_in          (resetn_in),
    .s_axi_arvalid_in   (s_axi_arvalid_in),
    .s_axi_arready_out  (s_axi_arready_out),
    .s_axi_rvalid_out   (s_axi_rvalid_out),
    .s_axi_bvalid_out   (s_axi_bvalid_out),
    .contour_step_in    (contour_step_in),
    .slave_role_out     (slave_role_out),
    .pos_loop_outer_out (pos_loop_outer_out),
    .contour_mask_out   (contour_mask_out),
    .axis_stopping_in   (axis_stopping_in),
    .vel_hold_out       (vel_hold_out),
    .vel_cmd_out        (vel_cmd_out)
);

// >>> test/axi_host_model.sv
// Host model issuing AXI4-Lite register writes and reads
`timescale 1ns/10ps
module axi_host_model (
    input  wire        clk_in,                                // Clock
    input  wire        s_axi_awready_out, s_axi_wready_out,   // Write ready
    input  wire        s_axi_bvalid_out, s_axi_arready_out,   // Handshakes
    input  wire        s_axi_rvalid_out,                      // Read valid
    input  wire [1:0]  s_axi_bresp_out, s_axi_rresp_out,      // Responses
    input  wire [31:0] s_axi_rdata_out,                       // Read data
    output reg  [7:0]  s_axi_awaddr_in, s_axi_araddr_in,      // Addresses
    output reg  [31:0] s_axi_wdata_in,                        // Write data
    output reg  [3:0]  s_axi_wstrb_in,                        // Strobes
    output reg         s_axi_awvalid_in, s_axi_wvalid_in,     // Write valid
    output reg         s_axi_bready_in, s_axi_arvalid_in,     // Ready, valid
    output reg         s_axi_rready_in                        // Read ready
);
    reg aw, w, b;
    // Idle bus at time zero
    initial
    begin
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
        s_axi_wstrb_in = 4'hF;
    end
    // Write: each channel held until its own ready edge
    task wr(input [7:0] a, input [31:0] dat, output [1:0] resp);
    begin
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= dat;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        {aw, w, b} = 3'h0;
        while (!b)
        begin
            @(negedge clk_in);
            aw = aw | s_axi_awready_out;
            w = w | s_axi_wready_out;
            b = s_axi_bvalid_out;
            resp = s_axi_bresp_out;
            @(posedge clk_in);
            {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {!aw, !w, !b};
        end
    end
    endtask
    // Read: address held until taken, data taken with rvalid
    task rd(input [7:0] a, output [31:0] dat, output [1:0] resp);
    begin
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        {aw, b} = 2'h0;
        while (!b)
        begin
            @(negedge clk_in);
            aw = aw | s_axi_arready_out;
            b = s_axi_rvalid_out;
            dat = s_axi_rdata_out;
            resp = s_axi_rresp_out;
            @(posedge clk_in);
            {s_axi_arvalid_in, s_axi_rready_in} <= {!aw, !b};
        end
    end
    endtask
endmodule // axi_host_model

// >>> test/motion_command_decoder_bench.sv
// Self-checking bench for the motion command decoder
`timescale 1ns/10ps
`include "motion_cmd_regs.vh"
module motion_command_decoder_bench;
    reg          clk_in, resetn_in, contour_step_in;
    reg  [7:0]   contour_pos_in;
    reg  [3:0]   axis_stopping_in;
    wire [7:0]   s_axi_awaddr_in, s_axi_araddr_in;
    wire [31:0]  s_axi_wdata_in, s_axi_rdata_out;
    wire [3:0]   s_axi_wstrb_in, contour_mask_out, vel_hold_out;
    wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
    wire         s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    wire         s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out;
    wire         s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    wire         s_axi_rvalid_out, slave_role_out, pos_loop_outer_out;
    wire [127:0] vel_cmd_out;
    reg  [31:0]  d;
    reg  [1:0]   r;
    integer      n_fail, checks_done, cycles, i;
    motion_command_decoder DUT (
        .clk_in             (clk_in),
        .resetn_in          (resetn_in),
        .s_axi_awaddr_in    (s_axi_awaddr_in),
        .s_axi_awvalid_in   (s_axi_awvalid_in),
        .s_axi_awready_out  (s_axi_awready_out),
        .s_axi_wdata_in     (s_axi_wdata_in),
        .s_axi_wstrb_in     (s_axi_wstrb_in),
        .s_axi_wvalid_in    (s_axi_wvalid_in),
        .s_axi_wready_out   (s_axi_wready_out),
        .s_axi_bresp_out    (s_axi_bresp_out),
        .s_axi_bvalid_out   (s_axi_bvalid_out),
        .s_axi_bready_in    (s_axi_bready_in),
        .s_axi_araddr_in    (s_axi_araddr_in),
        .s_axi_arvalid_in   (s_axi_arvalid_in),
        .s_axi_arready_out  (s_axi_arready_out),
        .s_axi_rdata_out    (s_axi_rdata_out),
        .s_axi_rresp_out    (s_axi_rresp_out),
        .s_axi_rvalid_out   (s_axi_rvalid_out),
        .s_axi_rready_in    (s_axi_rready_in),
        .contour_pos_in     (contour_pos_in),
        .contour_step_in    (contour_step_in),
        .axis_stopping_in   (axis_stopping_in),
        .slave_role_out     (slave_role_out),
        .contour_mask_out   (contour_mask_out),
        .vel_hold_out       (vel_hold_out),
        .vel_cmd_out        (vel_cmd_out),
        .pos_loop_outer_out (pos_loop_outer_out)
    );
    axi_host_model host (
        .clk_in             (clk_in),
        .s_axi_awready_out  (s_axi_awready_out),
        .s_axi_wready_out   (s_axi_wready_out),
        .s_axi_bvalid_out   (s_axi_bvalid_out),
        .s_axi_arready_out  (s_axi_arready_out),
        .s_axi_rvalid_out   (s_axi_rvalid_out),
        .s_axi_bresp_out    (s_axi_bresp_out),
        .s_axi_rresp_out    (s_axi_rresp_out),
        .s_axi_rdata_out    (s_axi_rdata_out),
        .s_axi_awaddr_in    (s_axi_awaddr_in),
        .s_axi_araddr_in    (s_axi_araddr_in),
        .s_axi_wdata_in     (s_axi_wdata_in),
        .s_axi_wstrb_in     (s_axi_wstrb_in),
        .s_axi_awvalid_in   (s_axi_awvalid_in),
        .s_axi_wvalid_in    (s_axi_wvalid_in),
        .s_axi_bready_in    (s_axi_bready_in),
        .s_axi_arvalid_in   (s_axi_arvalid_in),
        .s_axi_rready_in    (s_axi_rready_in)
    );
    // Compare and count
    task check(input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    // Arguments then command code
    task cmd(input [7:0] code, input [31:0] a0, input [31:0] a1);
    begin
        host.wr(`REG_ARG0, a0, r);
        host.wr(`REG_ARG1, a1, r);
        host.wr(`REG_CMD, {24'h0, code}, r);
    end
    endtask
    // One contouring step pulse
    task step(input [7:0] p);
    begin
        contour_pos_in <= p;
        contour_step_in <= 1'b1;
        @(posedge clk_in);
        contour_step_in <= 1'b0;
        @(posedge clk_in);
    end
    endtask
    // Counts and verdict
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // Clock and cycle ceiling
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
    // Test sequence
    initial
    begin
        {clk_in, resetn_in, contour_step_in, contour_pos_in, axis_stopping_in} = 15'h0;
        {n_fail, checks_done, cycles} = 0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        check(slave_role_out, 1'b0);
        host.rd(`REG_STATUS, d, r);
        check(d, 32'h0);
        host.rd(`REG_MAX_ACCEL_SETTING, d, r);
        check(d, `ACCEL_RESET);
        host.rd(8'h40, d, r);
        check(r, `RESP_SLVERR);
        host.wr(8'h44, 32'h1, r);
        check(r, `RESP_SLVERR);
        $display("test reset done");
        for (i = 0; i < 3; i = i + 1)
        begin
            d = (i == 0) ? 32'h1 : (i == 1) ? 32'h80 : 32'h0;
            cmd(`CMD_ROLE_SELECT, d, 32'h0);
            check(slave_role_out, d != 0);
        end
        $display("test role done");
        cmd(`CMD_AXIS_SET, 32'hF7, 32'h17);
        step(8'h16);
        check(contour_mask_out, `MASK_RESET);
        step(8'h17);
        check(contour_mask_out, 4'h7);
        for (i = 0; i < 4; i = i + 1)
            cmd(`CMD_AXIS_SET, 32'h1 << i, 32'h20 + i);
        host.rd(`REG_STATUS, d, r);
        check(d[`ST_PEND_LSB +: 2], 2'h3);
        check(d[`ST_IGNORED_BIT], 1'b1);
        host.rd(`REG_RINGPOS, d, r);
        check(d, 32'h20);
        step(8'h20);
        check(contour_mask_out, 4'h1);
        host.wr(`REG_STATUS, 32'h2, r);
        $display("test axis set done");
        host.wr(`REG_VEL1, 32'h0003B5C3, r);
        cmd(`CMD_VEL_HOLD, 32'h2, 32'h0);
        check(vel_hold_out, 4'h0);
        host.rd(`REG_STATUS, d, r);
        check(d[`ST_IGNORED_BIT], 1'b1);
        host.wr(`REG_STATUS, 32'h2, r);
        host.rd(`REG_STATUS, d, r);
        check(d[`ST_IGNORED_BIT], 1'b0);
        host.wr(`REG_VEL0, 32'h0400_0000, r);
        host.rd(`REG_VEL0, d, r);
        check(d, 32'hFC00_0000);
        host.wr(`REG_MAX_ACCEL_SETTING, 32'h0001_0000, r);
        axis_stopping_in <= 4'h1;
        cmd(`CMD_VEL_HOLD, 32'hF3, 32'h0);
        check(vel_hold_out, 4'h2);
        @(negedge clk_in);
        d = vel_cmd_out[63:32];
        check(d != 32'h0 && d < 32'h0003B5C3, 1'b1);
        @(negedge clk_in);
        check(vel_cmd_out[63:32] - d, 32'h0001_0000);
        repeat (10) @(posedge clk_in);
        check(vel_cmd_out[63:32], 32'h0003B5C3);
        check(vel_cmd_out[31:0], 32'h0);
        host.rd(`REG_STATUS, d, r);
        check(d[`ST_IGNORED_BIT], 1'b1);
        $display("test velocity hold done");
        stop_test;
    end
endmodule // motion_command_decoder_bench
